// ---- shared/adcsq_pkg.sv ----
// adcsq_pkg: constants and types of the converter sequencer
// assumes a 100 MHz bus clock and an axi4-lite register port
`default_nettype none
package adcsq_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          RES_W        = 10;
  localparam int          SRC_COUNT    = 24;
  // register byte addresses
  localparam logic [7:0]  OFS_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_TRIGGER  = 8'h04;
  localparam logic [7:0]  OFS_RES_HIGH = 8'h08;
  localparam logic [7:0]  OFS_RES_LOW  = 8'h0C;
  localparam logic [7:0]  OFS_ERROR    = 8'h10;
  localparam logic [7:0]  OFS_CHANNEL  = 8'h14;
  localparam logic [7:0]  OFS_STATUS   = 8'h18;
  localparam logic [7:0]  OFS_ACQ      = 8'h1C;
  // status field positions
  localparam int          ST_DONE_BIT  = 0;
  localparam int          ST_PEND_BIT  = 1;
  localparam int          ST_BUSY_BIT  = 2;
  localparam int          ST_PDWN_BIT  = 3;
  // trigger select codes
  localparam logic [4:0]  TRIG_OFF     = 5'h00;
  localparam logic [4:0]  TRIG_LAST_HW = 5'h18;
  localparam logic [4:0]  TRIG_RD_ERR  = 5'h1C;
  localparam logic [4:0]  TRIG_RD_RESH = 5'h1D;
  localparam logic [4:0]  TRIG_RD_CHAN = 5'h1F;
  // reset values
  localparam logic [4:0]  CONTROL_RST  = 5'h00;
  localparam logic [4:0]  TRIGGER_RST  = 5'h00;
  localparam logic [5:0]  CHANNEL_RST  = 6'h00;
  localparam logic [7:0]  ACQ_RST      = 8'h00;
  localparam logic [9:0]  RESULT_RST   = 10'h000;
  // timing and bus response codes
  localparam int          CLK_MHZ      = 100;
  localparam int          EXTRA_NS     = 40;
  localparam int          EXTRA_CYCLES = (EXTRA_NS * CLK_MHZ + 999) / 1000;
  localparam int          TAD_CYCLES   = 4;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic irq_en;
    logic cont;
    logic rc_clk;
    logic go;
    logic on;
  } adcsq_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_SAMPLE  = 2'b10,
    ST_CONVERT = 2'b11
  } adcsq_state_t;
endpackage
`default_nettype wire

// ---- test/adcsq_partner.sv ----
// adcsq_partner: trigger sources and analog comparator beside the sequencer
// assumes the bench only changes the input level while no conversion runs
`default_nettype none
module adcsq_partner (
  input  wire logic [adcsq_pkg::RES_W-1:0]     level,
  input  wire logic                            aclk,
  input  wire logic [adcsq_pkg::RES_W-1:0]     dac_code,
  output var logic [adcsq_pkg::SRC_COUNT-1:0]  trig_sources,
  output logic                                 comparator_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // level sits half a step above its code, so no trial ever ties
  assign comparator_out = {level, 1'b1} > {dac_code, 1'b0};
  initial trig_sources = '0;
  // one rising edge on a source, held three cycles
  task automatic fire(input int idx);
    trig_sources[idx] <= 1'b1;
    repeat (3) @(posedge aclk);
    trig_sources[idx] <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- test/adcsq_sequencer_tb_top.sv ----
// adcsq_sequencer_tb_top: register-level bench of the conversion sequencer
// assumes the partner model supplies triggers and the comparator
`default_nettype none
module adcsq_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TADP = 4;
  localparam int EXP  = 3;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [23:0] trig;
  logic        sleep, cmp, aen, sh, wake, flag, cstart;
  logic [9:0]  dac, level, r;
  int          n_fail, cmp_count, n_cs, n_wk, t0, c0, c1;

  adcsq_sequencer #(.TAD(TADP), .EXTRA(EXP)) u_adcsq_sequencer (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .trig_sources(trig),
    .device_sleep(sleep), .comparator_out(cmp), .analog_enable(aen),
    .sample_hold(sh), .dac_code(dac), .wake_request(wake),
    .conversion_done_flag(flag), .compute_start(cstart));
  adcsq_partner u_adcsq_partner (.aclk(aclk), .level(level),
    .dac_code(dac), .trig_sources(trig), .comparator_out(cmp));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // counts of one-cycle pulses
  always @(posedge aclk)
  begin
    if (cstart === 1'b1) n_cs++;
    if (wake === 1'b1) n_wk++;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    rsp = bresp;
    if (n >= 50) n_fail++;
  endtask
  task automatic rdt(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    d = rdata;
    rsp = rresp;
    if (n >= 50) n_fail++;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    rdt(a, rd);
    chk(rd & m, e);
  endtask
  task automatic wflag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 300)
    begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, flag}, 32'h1);
  endtask
  task automatic pollgo();
    int n;
    n = 0;
    rd = 32'h2;
    while (rd[1] !== 1'b0 && n < 100)
    begin
      rdt(adcsq_pkg::OFS_CONTROL, rd);
      n++;
    end
    chk(rd, 32'h1);
  endtask
  task automatic lat(input logic [31:0] ctl, output int c);
    wr(adcsq_pkg::OFS_STATUS, 32'h1);
    fork
      wr(adcsq_pkg::OFS_CONTROL, ctl);
      begin
        c = 0;
        while (sh !== 1'b1 && c < 200)
        begin
          @(posedge aclk);
          c++;
        end
      end
    join
    wflag();
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    summarize();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep} = '0;
    {awaddr, araddr, wdata, n_fail, cmp_count, n_cs, n_wk} = '0;
    wstrb = 4'hF;
    level = 10'h2A5;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rchk(8'(i * 4), 32'hFFFFFFFF, 32'h0);
    rdt(8'h40, rd);
    chk({30'h0, rsp}, {30'h0, adcsq_pkg::RESP_SLVERR});
    wr(8'h40, 32'h0);
    chk({30'h0, rsp}, {30'h0, adcsq_pkg::RESP_SLVERR});
    // software start, then poll go
    wr(adcsq_pkg::OFS_CONTROL, 32'h01);
    wr(adcsq_pkg::OFS_CHANNEL, 32'h05);
    chk({30'h0, rsp}, {30'h0, adcsq_pkg::RESP_OKAY});
    repeat (TADP) @(posedge aclk);
    t0 = n_cs;
    wr(adcsq_pkg::OFS_CONTROL, 32'h03);
    pollgo();
    rchk(adcsq_pkg::OFS_RES_HIGH, 32'hFF, 32'h2);
    rchk(adcsq_pkg::OFS_RES_LOW, 32'hFF, 32'hA5);
    rchk(adcsq_pkg::OFS_STATUS, 32'h1, 32'h1);
    chk(n_cs - t0, 1);
    // continuous mode keeps go set
    wr(adcsq_pkg::OFS_STATUS, 32'h1);
    wr(adcsq_pkg::OFS_CONTROL, 32'h0B);
    wflag();
    rchk(adcsq_pkg::OFS_CONTROL, 32'h2, 32'h2);
    wr(adcsq_pkg::OFS_CONTROL, 32'h01);
    // abort in mid-conversion
    level <= 10'h333;
    wr(adcsq_pkg::OFS_STATUS, 32'h1);
    t0 = n_cs;
    wr(adcsq_pkg::OFS_CONTROL, 32'h03);
    repeat (16) @(posedge aclk);
    wr(adcsq_pkg::OFS_CONTROL, 32'h01);
    repeat (4) @(posedge aclk);
    rdt(adcsq_pkg::OFS_RES_HIGH, rd);
    r[9:8] = rd[1:0];
    rdt(adcsq_pkg::OFS_RES_LOW, rd);
    r[7:0] = rd[7:0];
    chk(32'(r inside {10'h3FF, 10'h300, 10'h33F, 10'h330}), 1);
    chk(n_cs - t0, 1);
    // extra start delay on the rc clock
    lat(32'h03, c0);
    lat(32'h07, c1);
    chk(c1 - c0, EXP);
    // every hardware source, then code zero
    level <= 10'h0F0;
    wr(adcsq_pkg::OFS_CONTROL, 32'h01);
    for (int i = 1; i <= 24; i++)
    begin
      wr(adcsq_pkg::OFS_STATUS, 32'h1);
      wr(adcsq_pkg::OFS_TRIGGER, i);
      u_adcsq_partner.fire(i - 1);
      wflag();
    end
    rchk(adcsq_pkg::OFS_RES_LOW, 32'hFF, 32'hF0);
    wr(adcsq_pkg::OFS_STATUS, 32'h1);
    wr(adcsq_pkg::OFS_TRIGGER, 32'h0);
    u_adcsq_partner.fire(0);
    u_adcsq_partner.fire(23);
    rchk(adcsq_pkg::OFS_STATUS, 32'h5, 32'h0);
    // register-read triggers
    for (int i = 0; i < 3; i++)
    begin
      wr(adcsq_pkg::OFS_STATUS, 32'h1);
      wr(adcsq_pkg::OFS_TRIGGER,
         i == 0 ? 32'h1C : i == 1 ? 32'h1D : 32'h1F);
      rdt(i == 0 ? adcsq_pkg::OFS_ERROR : i == 1 ?
          adcsq_pkg::OFS_RES_HIGH : adcsq_pkg::OFS_CHANNEL, rd);
      wflag();
    end
    // sleep on the rc clock, wake enabled then disabled
    wr(adcsq_pkg::OFS_TRIGGER, 32'h02);
    for (int i = 0; i < 2; i++)
    begin
      wr(adcsq_pkg::OFS_STATUS, 32'h1);
      wr(adcsq_pkg::OFS_CONTROL, i == 0 ? 32'h15 : 32'h05);
      sleep <= 1'b1;
      t0 = n_wk;
      u_adcsq_partner.fire(1);
      wflag();
      repeat (3) @(posedge aclk);
      chk(n_wk - t0, i == 0 ? 1 : 0);
      chk({31'h0, aen}, i == 0 ? 1 : 0);
      rchk(adcsq_pkg::OFS_CONTROL, 32'h1, 32'h1);
      sleep <= 1'b0;
    end
    // sleep on the system clock: trigger waits for wake-up
    wr(adcsq_pkg::OFS_CONTROL, 32'h00);
    wr(adcsq_pkg::OFS_STATUS, 32'h1);
    wr(adcsq_pkg::OFS_CONTROL, 32'h01);
    sleep <= 1'b1;
    t0 = n_cs;
    u_adcsq_partner.fire(1);
    repeat (60) @(posedge aclk);
    rchk(adcsq_pkg::OFS_STATUS, 32'h7, 32'h2);
    sleep <= 1'b0;
    wflag();
    repeat (100) @(posedge aclk);
    chk(n_cs - t0, 1);
    rchk(adcsq_pkg::OFS_STATUS, 32'h2, 32'h0);
    // reset in mid-conversion
    wr(adcsq_pkg::OFS_CONTROL, 32'h03);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({19'h0, flag, aen, sh, dac}, 32'h0);
    aresetn <= 1'b1;
    rchk(adcsq_pkg::OFS_CONTROL, 32'hFF, 32'h0);
    repeat (80) @(posedge aclk);
    rchk(adcsq_pkg::OFS_STATUS, 32'hFF, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// ---- verilog/adcsq_sequencer.sv ----
// adcsq_sequencer: 10-bit sar conversion sequencer with axi4-lite registers
// assumes trigger sources and comparator are asynchronous, sleep is on aclk
`default_nettype none
module adcsq_sequencer #(
  parameter int TAD     = adcsq_pkg::TAD_CYCLES,
  parameter int EXTRA   = adcsq_pkg::EXTRA_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [adcsq_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [adcsq_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic [adcsq_pkg::SRC_COUNT-1:0] trig_sources,
  input  wire logic                        device_sleep,
  input  wire logic                        comparator_out,
  output logic                             analog_enable,
  output logic                             sample_hold,
  output logic [adcsq_pkg::RES_W-1:0]      dac_code,
  output logic                             wake_request,
  output logic                             conversion_done_flag,
  output logic                             compute_start
);
  // comparator needs two sync flops plus one cycle inside each bit
  if (TAD < 3 || TAD > 255 || EXTRA < 1 || EXTRA > 255)
    $error("adcsq_sequencer: TAD must be 3 to 255, EXTRA 1 to 255");

  adcsq_pkg::adcsq_ctrl_t  ctrl;
  adcsq_pkg::adcsq_state_t state;
  logic [4:0]  auto_trigger_select;
  logic [5:0]  channel_select;
  logic [7:0]  acquisition_time;
  logic [9:0]  result;
  logic [9:0]  error_value;
  logic [9:0]  sar;
  logic [3:0]  bit_idx;
  logic        last_bit;
  logic [7:0]  cnt;
  logic        pending;
  logic        powered_down;
  logic [adcsq_pkg::SRC_COUNT-1:0] src_s1;
  logic [adcsq_pkg::SRC_COUNT-1:0] src_s2;
  logic        cmp_s1;
  logic        cmp_s2;
  logic        sel_prev;
  logic        read_trig;
  logic        next_go;

  // bus handshakes and decoded strobes
  wire logic wr_fire = awvalid && awready && wvalid && wready;
  wire logic rd_fire = arvalid && arready;
  wire logic wr_ctrl = wr_fire && wstrb[0] && awaddr == adcsq_pkg::OFS_CONTROL;
  wire logic wr_stat = wr_fire && wstrb[0] && awaddr == adcsq_pkg::OFS_STATUS;
  wire logic busy    = state != adcsq_pkg::ST_IDLE;
  wire logic run_ok  = !device_sleep || ctrl.rc_clk;
  wire logic tad_end = cnt == 8'(TAD - 1);
  wire logic done_evt = state == adcsq_pkg::ST_CONVERT && run_ok && tad_end
                        && bit_idx == 4'h0;

  // selected hardware source; codes above 0x18 are not hardware sources
  wire logic hw_valid = auto_trigger_select != adcsq_pkg::TRIG_OFF
                        && auto_trigger_select <= adcsq_pkg::TRIG_LAST_HW;
  wire logic sel_src = hw_valid && src_s2[auto_trigger_select - 5'h01];
  wire logic hw_trig = sel_src && !sel_prev;
  wire logic trig_any = ctrl.on && (hw_trig || read_trig);
  wire logic trig_go  = trig_any && run_ok;
  wire logic launch   = state == adcsq_pkg::ST_IDLE && ctrl.go && ctrl.on
                        && run_ok;
  wire logic abort_evt = busy && !next_go && !done_evt;

  // unresolved bits take the most recent resolved bit
  function automatic logic [9:0] adcsq_fill(input logic [9:0] r,
                                            input logic [3:0] b,
                                            input logic       v);
    logic [9:0] f;
    f = r;
    for (int i = 0; i < 10; i++)
      if (4'(i) <= b)
        f[i] = v;
    return f;
  endfunction

  // two-flop synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_s1 <= '0;
      src_s2 <= '0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      sel_prev <= 1'b0;
    end
    else
    begin
      src_s1 <= trig_sources;
      src_s2 <= src_s1;
      cmp_s1 <= comparator_out;
      cmp_s2 <= cmp_s1;
      sel_prev <= sel_src;
    end
  end

  // axi4-lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= adcsq_pkg::RESP_OKAY;
    end
    else
    begin
      awready <= !awready && awvalid && wvalid && !bvalid;
      wready  <= !wready && awvalid && wvalid && !bvalid;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp  <= (awaddr[1:0] == 2'h0 && awaddr <= adcsq_pkg::OFS_ACQ)
                  ? adcsq_pkg::RESP_OKAY : adcsq_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // axi4-lite read channel; some reads also fire a trigger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= adcsq_pkg::RESP_OKAY;
      read_trig <= 1'b0;
    end
    else
    begin
      arready   <= !arready && arvalid && !rvalid;
      read_trig <= rd_fire && (
        (araddr == adcsq_pkg::OFS_ERROR
         && auto_trigger_select == adcsq_pkg::TRIG_RD_ERR) ||
        (araddr == adcsq_pkg::OFS_RES_HIGH
         && auto_trigger_select == adcsq_pkg::TRIG_RD_RESH) ||
        (araddr == adcsq_pkg::OFS_CHANNEL
         && auto_trigger_select == adcsq_pkg::TRIG_RD_CHAN));
      if (rd_fire)
      begin
        rvalid <= 1'b1;
        rresp  <= adcsq_pkg::RESP_OKAY;
        unique case (araddr)
          adcsq_pkg::OFS_CONTROL:  rdata <= {27'h0, ctrl};
          adcsq_pkg::OFS_TRIGGER:  rdata <= {27'h0, auto_trigger_select};
          adcsq_pkg::OFS_RES_HIGH: rdata <= {30'h0, result[9:8]};
          adcsq_pkg::OFS_RES_LOW:  rdata <= {24'h0, result[7:0]};
          adcsq_pkg::OFS_ERROR:    rdata <= {22'h0, error_value};
          adcsq_pkg::OFS_CHANNEL:  rdata <= {26'h0, channel_select};
          adcsq_pkg::OFS_STATUS:   rdata <= {28'h0, powered_down, busy,
                                             pending, conversion_done_flag};
          adcsq_pkg::OFS_ACQ:      rdata <= {24'h0, acquisition_time};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= adcsq_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // go bit: hardware clear, software write, trigger set wins
  always_comb
  begin
    next_go = ctrl.go;
    if (done_evt && !ctrl.cont)
      next_go = 1'b0;
    if (wr_ctrl)
      next_go = wdata[1] && wdata[0];
    if (trig_go || (pending && !device_sleep && ctrl.on))
      next_go = 1'b1;
  end

  // software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl                <= adcsq_pkg::CONTROL_RST;
      auto_trigger_select <= adcsq_pkg::TRIGGER_RST;
      channel_select      <= adcsq_pkg::CHANNEL_RST;
      acquisition_time    <= adcsq_pkg::ACQ_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= wdata[4:0];
      ctrl.go <= next_go;
      if (wr_fire && wstrb[0] && awaddr == adcsq_pkg::OFS_TRIGGER)
        auto_trigger_select <= wdata[4:0];
      if (wr_fire && wstrb[0] && awaddr == adcsq_pkg::OFS_CHANNEL)
        channel_select <= wdata[5:0];
      if (wr_fire && wstrb[0] && awaddr == adcsq_pkg::OFS_ACQ)
        acquisition_time <= wdata[7:0];
    end
  end

  // pending trigger while asleep on the system clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending <= 1'b0;
    else if (trig_any && !run_ok)
      pending <= 1'b1;
    else if (!device_sleep || !ctrl.on)
      pending <= 1'b0;
  end

  // conversion engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state    <= adcsq_pkg::ST_IDLE;
      cnt      <= 8'h00;
      sar      <= 10'h000;
      bit_idx  <= 4'h9;
      last_bit <= 1'b0;
      dac_code <= 10'h000;
    end
    else if (abort_evt)
      state <= adcsq_pkg::ST_IDLE;
    else if (run_ok)
    begin
      cnt <= cnt + 8'h01;
      unique case (state)
        adcsq_pkg::ST_IDLE:
        begin
          cnt <= 8'h00;
          if (launch)
            state <= ctrl.rc_clk ? adcsq_pkg::ST_DELAY
                                 : adcsq_pkg::ST_SAMPLE;
        end
        adcsq_pkg::ST_DELAY:
          if (cnt == 8'(EXTRA - 1))
          begin
            cnt   <= 8'h00;
            state <= adcsq_pkg::ST_SAMPLE;
          end
        adcsq_pkg::ST_SAMPLE:
          if (tad_end)
          begin
            cnt      <= 8'h00;
            sar      <= 10'h000;
            bit_idx  <= 4'h9;
            last_bit <= 1'b0;
            dac_code <= 10'h200;
            state    <= adcsq_pkg::ST_CONVERT;
          end
        adcsq_pkg::ST_CONVERT:
          if (tad_end)
          begin
            cnt      <= 8'h00;
            sar[bit_idx] <= cmp_s2;
            last_bit <= cmp_s2;
            dac_code[bit_idx] <= cmp_s2;
            if (bit_idx == 4'h0)
              state <= adcsq_pkg::ST_IDLE;
            else
            begin
              bit_idx <= bit_idx - 4'h1;
              dac_code[bit_idx - 4'h1] <= 1'b1;
            end
          end
      endcase
    end
  end

  // results, flag, computation start and sleep handling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result               <= adcsq_pkg::RESULT_RST;
      error_value          <= adcsq_pkg::RESULT_RST;
      conversion_done_flag <= 1'b0;
      compute_start        <= 1'b0;
      wake_request         <= 1'b0;
      powered_down         <= 1'b0;
      analog_enable        <= 1'b0;
      sample_hold          <= 1'b0;
    end
    else
    begin
      compute_start <= done_evt || abort_evt;
      wake_request  <= done_evt && device_sleep && ctrl.irq_en;
      if (done_evt)
        result <= {sar[9:1], cmp_s2};
      else if (abort_evt)
        result <= (state == adcsq_pkg::ST_CONVERT)
                  ? adcsq_fill(sar, bit_idx, last_bit)
                  : 10'h000;
      if (compute_start)
        error_value <= result - error_value;
      conversion_done_flag <= done_evt
        || (conversion_done_flag
            && !(wr_stat && wdata[adcsq_pkg::ST_DONE_BIT]));
      if (done_evt && device_sleep && !ctrl.irq_en)
        powered_down <= 1'b1;
      else if (!device_sleep || launch)
        powered_down <= 1'b0;
      analog_enable <= ctrl.on && !powered_down
                       && !(done_evt && device_sleep && !ctrl.irq_en);
      // the hold capacitor is only connected, never discharged
      sample_hold <= state == adcsq_pkg::ST_SAMPLE;
    end
  end

  a_abort_to_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_evt |=> state == adcsq_pkg::ST_IDLE && !ctrl.go && compute_start)
    else $error("abort did not end the conversion");
  a_abort_fill_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    (abort_evt && state == adcsq_pkg::ST_CONVERT)
    |=> result[0] == $past(last_bit))
    else $error("unresolved bits not filled");
  a_abort_compute: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_evt |=> compute_start ##1 !compute_start)
    else $error("abort missed computation start");
  a_sleep_no_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == adcsq_pkg::ST_IDLE && device_sleep && !ctrl.rc_clk)
    |=> state == adcsq_pkg::ST_IDLE)
    else $error("conversion started in sleep");
  a_rc_extra_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    (launch && ctrl.rc_clk && !abort_evt) |=> state == adcsq_pkg::ST_DELAY)
    else $error("rc start not delayed");
  a_sleep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_evt && device_sleep && ctrl.irq_en) |=> wake_request && analog_enable)
    else $error("no wake on completion");
  a_sleep_pdown: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_evt && device_sleep && !ctrl.irq_en && !wr_ctrl)
    |=> !analog_enable && powered_down && ctrl.on)
    else $error("no power down after sleep conversion");
  a_trig_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_any && !run_ok) |=> pending && state == adcsq_pkg::ST_IDLE)
    else $error("sleep trigger not held pending");
  a_done_clears_go: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_evt && !ctrl.cont && !wr_ctrl && !trig_go && !pending)
    |=> !ctrl.go && conversion_done_flag)
    else $error("completion handling wrong");
  a_trig_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_trigger_select == adcsq_pkg::TRIG_OFF |-> !hw_trig && !read_trig)
    else $error("trigger while disabled");
endmodule
`default_nettype wire
